// ===== shared/wdog_pkg.sv
// package for the keyed watchdog: register map, field layout, reset values, timing
// assumes a 25 MHz system clock and a 32-bit apb register bus
package wdog_pkg;
    localparam logic [7:0] ADDR_COUNT = 8'h00;
    localparam logic [7:0] ADDR_PERIOD = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_SCR = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    localparam int SCR_FLAG_BIT = 15;
    localparam int SCR_EN_BIT = 14;
    localparam int SCR_RSVD_BIT = 13;
    localparam int SCR_PRESCALE_MODE_SELECT_BIT = 12;
    localparam int KEY_W = 12;
    localparam int DIV_W = 4;
    localparam int CNT_W = 16;

    localparam logic [11:0] KEY_ARM = 12'h5C6;
    localparam logic [11:0] KEY_SERVE = 12'hA7E;

    localparam logic [15:0] COUNT_RST = 16'hFFFF;
    localparam logic [15:0] PERIOD_RST = 16'hFFFF;
    localparam logic [3:0] DIV_RST = 4'hF;
    localparam logic PRESCALE_MODE_SELECT_RST = 1'b1;
    localparam logic [11:0] KEY_RST = 12'h000;

    localparam int CLK_PERIOD_PS = 40000;
    localparam int PULSE_HALF_CYCLES = 6;
    localparam int PULSE_CYC = (PULSE_HALF_CYCLES + 1) / 2;

    typedef enum logic [3:0] {
        ST_DISABLED = 4'b0001,
        ST_PREACTIVE = 4'b0010,
        ST_ACTIVE = 4'b0100,
        ST_SERVICE = 4'b1000
    } key_state_e;

    typedef struct packed {
        logic flag;
        logic en;
        logic rsvd;
        logic prescale_mode_select;
        logic [11:0] key;
    } scr_s;
endpackage

// ===== src/keyed_watchdog_control.sv
// keyed watchdog: prescaler, down counter, key state machine and apb register file
// assumes apb master on clk_sys; timeout_output_pin_n is a synchronous pin driver
`timescale 1ns/1ps
module keyed_watchdog_control #(
    parameter int PULSE_CYCLES = wdog_pkg::PULSE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic timeout_output_pin_n,
    output logic watchdog_interrupt
);
    import wdog_pkg::*;

    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 7) begin : g_bad_pulse
        $error("PULSE_CYCLES out of range");
    end

    // indirect preset: code n gives n+1 ones
    function automatic logic [CNT_W-1:0] preset_value(input logic [DIV_W-1:0] code);
        logic [CNT_W-1:0] v;
        v = '0;
        for (int i = 0; i < CNT_W; i++) begin
            if (i <= int'(code)) begin
                v[i] = 1'b1;
            end
        end
        return v;
    endfunction

    function automatic logic is_valid_key(input logic [KEY_W-1:0] k);
        return (k == KEY_ARM) || (k == KEY_SERVE);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a == ADDR_COUNT) || (a == ADDR_PERIOD) || (a == ADDR_CTRL) ||
            (a == ADDR_SCR) || (a == ADDR_STATUS);
    endfunction

    key_state_e state_r;
    key_state_e state_nxt;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] period_r;
    logic [CNT_W-1:0] prescale_counter_r;
    logic [DIV_W-1:0] prescale_divide_field_r;
    logic timeout_flag_r;
    logic watchdog_enable_bit_r;
    logic prescale_mode_select_r;
    logic [KEY_W-1:0] service_key_field_r;
    logic [2:0] pulse_left_r;
    logic pin_n_r;
    logic irq_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    logic access;
    logic wr;
    logic rd;
    logic scr_wr;
    logic count_wr;
    logic [KEY_W-1:0] wkey;
    logic [CNT_W-1:0] prescale_reload;
    logic prescale_tick;
    logic count_expire;
    logic key_timeout;
    logic timeout_evt;
    logic service_reload;
    logic activate;
    scr_s scr_view;

    assign access = psel && penable;
    assign wr = access && pwrite && mapped(paddr);
    assign rd = access && !pwrite;
    assign scr_wr = wr && (paddr == ADDR_SCR);
    assign count_wr = wr && (paddr == ADDR_COUNT) && !watchdog_enable_bit_r;
    assign wkey = pwdata[KEY_W-1:0];
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign timeout_output_pin_n = pin_n_r;
    assign watchdog_interrupt = irq_r;

    assign prescale_reload = prescale_mode_select_r ? preset_value(prescale_divide_field_r)
        : {{(CNT_W-DIV_W){1'b0}}, prescale_divide_field_r};
    assign prescale_tick = (prescale_counter_r == '0);
    assign count_expire = prescale_tick && (count_r == '0);

    assign key_timeout = scr_wr && (state_r == ST_ACTIVE || state_r == ST_SERVICE) && !is_valid_key(wkey);
    assign timeout_evt = key_timeout || (count_expire && watchdog_enable_bit_r);
    assign activate = scr_wr && (state_r == ST_PREACTIVE) && (wkey == KEY_SERVE) && pwdata[SCR_EN_BIT];
    assign service_reload = scr_wr && (state_r == ST_SERVICE) && (wkey == KEY_SERVE);

    // key state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_DISABLED: begin
                if (scr_wr && wkey == KEY_ARM) begin
                    state_nxt = ST_PREACTIVE;
                end
            end
            ST_PREACTIVE: begin
                if (activate) begin
                    state_nxt = ST_ACTIVE;
                end else if (scr_wr && wkey != KEY_ARM) begin
                    state_nxt = ST_DISABLED;
                end
            end
            ST_ACTIVE: begin
                if (scr_wr && wkey == KEY_ARM) begin
                    state_nxt = ST_SERVICE;
                end
            end
            ST_SERVICE: begin
                if (scr_wr && wkey == KEY_SERVE) begin
                    state_nxt = ST_ACTIVE;
                end
            end
            default: begin
                state_nxt = ST_DISABLED;
            end
        endcase
        if (timeout_evt) begin
            state_nxt = ST_DISABLED;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_DISABLED;
        end else begin
            state_r <= state_nxt;
        end
    end

    // prescale counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prescale_counter_r <= preset_value(DIV_RST);
        end else if (timeout_evt || service_reload || prescale_tick || count_wr) begin
            // prescaler reload
            // counter write also restarts the prescaler
            prescale_counter_r <= prescale_reload;
        end else begin
            prescale_counter_r <= prescale_counter_r - 1'b1;
        end
    end

    // watchdog counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= COUNT_RST;
        end else if (timeout_evt || service_reload || count_expire) begin
            count_r <= period_r;
        end else if (count_wr) begin
            count_r <= pwdata[CNT_W-1:0];
        end else if (prescale_tick) begin
            count_r <= count_r - 1'b1;
        end
    end

    // period and control registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            period_r <= PERIOD_RST;
            prescale_divide_field_r <= DIV_RST;
        end else if (wr && !watchdog_enable_bit_r) begin
            if (paddr == ADDR_PERIOD) begin
                period_r <= pwdata[CNT_W-1:0];
            end
            if (paddr == ADDR_CTRL) begin
                prescale_divide_field_r <= pwdata[DIV_W-1:0];
            end
        end
    end

    // second control fields
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timeout_flag_r <= 1'b0;
            watchdog_enable_bit_r <= 1'b0;
            prescale_mode_select_r <= PRESCALE_MODE_SELECT_RST;
            service_key_field_r <= KEY_RST;
        end else begin
            if (scr_wr) begin
                service_key_field_r <= wkey;
            end
            if (scr_wr && !watchdog_enable_bit_r) begin
                prescale_mode_select_r <= pwdata[SCR_PRESCALE_MODE_SELECT_BIT];
            end
            if (timeout_evt) begin
                watchdog_enable_bit_r <= 1'b0;
            end else if (activate) begin
                watchdog_enable_bit_r <= 1'b1;
            end
            if (timeout_evt) begin
                timeout_flag_r <= 1'b1;
            end else if (activate) begin
                timeout_flag_r <= 1'b0;
            end else if (scr_wr && !watchdog_enable_bit_r && pwdata[SCR_FLAG_BIT]) begin
                timeout_flag_r <= 1'b0;
            end
        end
    end

    // output pulse and interrupt
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_n_r <= 1'b1;
            pulse_left_r <= 3'd0;
            irq_r <= 1'b0;
        end else begin
            irq_r <= timeout_evt || count_expire;
            if (timeout_evt) begin
                pin_n_r <= 1'b0;
                pulse_left_r <= 3'(PULSE_CYCLES - 1);
            end else if (pulse_left_r != 3'd0) begin
                pulse_left_r <= pulse_left_r - 3'd1;
            end else begin
                pin_n_r <= 1'b1;
            end
        end
    end

    always_comb begin
        scr_view.flag = timeout_flag_r;
        scr_view.en = watchdog_enable_bit_r;
        scr_view.rsvd = 1'b0;
        scr_view.prescale_mode_select = prescale_mode_select_r;
        scr_view.key = service_key_field_r;
    end

    // apb read data and error
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pslverr_r <= 1'b0;
            if (psel && !penable) begin
                pslverr_r <= !mapped(paddr);
                prdata_r <= 32'h0000_0000;
                if (!pwrite) begin
                    case (paddr)
                        ADDR_COUNT: prdata_r <= {16'h0000, count_r};
                        ADDR_PERIOD: prdata_r <= {16'h0000, period_r};
                        ADDR_CTRL: prdata_r <= {28'h000_0000, prescale_divide_field_r};
                        ADDR_SCR: prdata_r <= {16'h0000, scr_view};
                        ADDR_STATUS: prdata_r <= {28'h000_0000, state_r};
                        default: prdata_r <= 32'h0000_0000;
                    endcase
                end
            end else if (access) begin
                pslverr_r <= 1'b0;
                if (rd) begin
                    prdata_r <= prdata_r;
                end
            end
        end
    end
endmodule

// ===== bench/keyed_watchdog_control_sva.sv
// checker for the keyed watchdog: apb answers, key sequence and time-out pulse
// assumes bind onto keyed_watchdog_control, one clock domain, reset rst_n
`timescale 1ns/1ps
module keyed_watchdog_control_sva
    import wdog_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timeout_output_pin_n,
    input wire logic watchdog_interrupt
);
    logic [1:0] mode_r;
    logic [3:0] low_cnt_r;
    logic scr_wr;
    logic [11:0] key;
    assign scr_wr = psel && penable && pwrite && paddr == ADDR_SCR;
    assign key = pwdata[11:0];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // shadow key state: 0 off, 1 pre, 2 active, 3 service
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= 2'd0;
        end else if (scr_wr) begin
            if (key == KEY_ARM) begin
                mode_r <= (mode_r == 2'd0) ? 2'd1 : (mode_r == 2'd1) ? 2'd1 : 2'd3;
            end else if (key == KEY_SERVE && (mode_r[1] || pwdata[SCR_EN_BIT])) begin
                mode_r <= (mode_r == 2'd0) ? 2'd0 : 2'd2;
            end else begin
                mode_r <= 2'd0;
            end
        end else if (!timeout_output_pin_n) begin
            mode_r <= 2'd0;
        end
    end
    // low time of the pin, in clocks
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_r <= 4'h0;
        end else begin
            low_cnt_r <= timeout_output_pin_n ? 4'h0 : low_cnt_r + 4'h1;
        end
    end
    sequence s_bad_key;
        scr_wr && mode_r[1] && key != KEY_ARM && key != KEY_SERVE;
    endsequence
    sequence s_good_key;
        scr_wr && mode_r[1] && (key == KEY_ARM || key == KEY_SERVE);
    endsequence
    sequence s_timeout;
        !timeout_output_pin_n && watchdog_interrupt ##1 !watchdog_interrupt;
    endsequence
    property p_pulse_len;
        $rose(timeout_output_pin_n) |-> low_cnt_r == PULSE_CYCLES;
    endproperty
    property p_pulse_max;
        !timeout_output_pin_n |-> low_cnt_r < PULSE_CYCLES;
    endproperty
    property p_pulse_irq;
        $fell(timeout_output_pin_n) |-> watchdog_interrupt;
    endproperty
    property p_bad_key;
        s_bad_key |=> s_timeout;
    endproperty
    property p_good_key;
        s_good_key |=> timeout_output_pin_n;
    endproperty
    property p_pin_gate;
        $fell(timeout_output_pin_n) |-> $past(mode_r[1]);
    endproperty
    property p_rsvd;
        psel && penable && !pwrite && paddr == ADDR_SCR |-> !prdata[SCR_RSVD_BIT] && prdata[31:16] == 16'h0000;
    endproperty
    property p_err;
        psel && penable && paddr > ADDR_STATUS |-> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
    a_pulse_max: assert property (p_pulse_max) else $error("pulse too long");
    a_pulse_irq: assert property (p_pulse_irq) else $error("pulse without interrupt");
    a_bad_key: assert property (p_bad_key) else $error("bad key gave no time-out");
    a_good_key: assert property (p_good_key) else $error("valid key gave time-out");
    a_pin_gate: assert property (p_pin_gate) else $error("pin pulsed while not enabled");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule
bind keyed_watchdog_control keyed_watchdog_control_sva #(.PULSE_CYCLES(PULSE_CYCLES)) sva_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .timeout_output_pin_n(timeout_output_pin_n),
    .watchdog_interrupt(watchdog_interrupt)
);

// ===== bench/keyed_watchdog_control_bench.sv
// self-checking bench for the keyed watchdog over apb
// assumes the checker is bound to the design; 25 MHz clock
`timescale 1ns/1ps
module keyed_watchdog_control_bench;
    import wdog_pkg::*;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, timeout_output_pin_n, watchdog_interrupt;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    int n_fail, tests_run, n_pulse, n;
    keyed_watchdog_control dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timeout_output_pin_n(timeout_output_pin_n),
        .watchdog_interrupt(watchdog_interrupt));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(negedge timeout_output_pin_n) n_pulse++;
    task finish_test;
        if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rdata = prdata;
        chk({31'h0, pslverr}, {31'h0, a > ADDR_STATUS});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdata, exp);
    endtask
    task wait_irq;
        n = 0;
        @(posedge clk_sys);
        while (watchdog_interrupt !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        chk({31'h0, watchdog_interrupt}, 32'h0000_0001);
    endtask
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ADDR_COUNT, 32'h0000_FFFF);
        rd(ADDR_PERIOD, 32'h0000_FFFF);
        rd(ADDR_CTRL, 32'h0000_000F);
        rd(ADDR_SCR, 32'h0000_1000);
        rd(ADDR_STATUS, 32'h0000_0001);
        rd(8'h14, 32'h0000_0000);
        apb(1'b1, ADDR_SCR, 32'h0000_7000);
        rd(ADDR_SCR, 32'h0000_1000);
        apb(1'b1, ADDR_PERIOD, 32'h0000_0003);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        apb(1'b1, ADDR_COUNT, 32'h0000_0003);
        apb(1'b1, ADDR_SCR, 32'h0000_0000);
        wait_irq();
        wait_irq();
        chk(32'(n), 32'((3 + 1) * (1 + 1) - 1));
        chk(32'(n_pulse), 32'h0000_0000);
        apb(1'b1, ADDR_SCR, 32'h0000_1000);
        wait_irq();
        wait_irq();
        chk(32'(n), 32'((3 + 1) * (3 + 1) - 1));
        apb(1'b1, ADDR_PERIOD, 32'h0000_FFFF);
        apb(1'b1, ADDR_COUNT, 32'h0000_FFFF);
        apb(1'b1, ADDR_CTRL, 32'h0000_000F);
        apb(1'b1, ADDR_SCR, 32'h0000_05C6);
        rd(ADDR_STATUS, 32'h0000_0002);
        apb(1'b1, ADDR_SCR, 32'h0000_4A7E);
        rd(ADDR_STATUS, 32'h0000_0004);
        rd(ADDR_SCR, 32'h0000_4A7E);
        apb(1'b1, ADDR_PERIOD, 32'h0000_0010);
        rd(ADDR_PERIOD, 32'h0000_FFFF);
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
        rd(ADDR_CTRL, 32'h0000_000F);
        apb(1'b1, ADDR_SCR, 32'h0000_95C6);
        rd(ADDR_SCR, 32'h0000_45C6);
        rd(ADDR_STATUS, 32'h0000_0008);
        apb(1'b1, ADDR_SCR, 32'h0000_0A7E);
        rd(ADDR_COUNT, 32'h0000_FFFF);
        rd(ADDR_STATUS, 32'h0000_0004);
        chk(32'(n_pulse), 32'h0000_0000);
        apb(1'b1, ADDR_SCR, 32'h0000_0123);
        #1;
        chk({30'h0, timeout_output_pin_n, watchdog_interrupt}, 32'h0000_0001);
        n = 0;
        while (timeout_output_pin_n === 1'b0 && n < 10) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(32'(n), 32'(PULSE_CYC));
        rd(ADDR_SCR, 32'h0000_8123);
        rd(ADDR_STATUS, 32'h0000_0001);
        apb(1'b1, ADDR_SCR, 32'h0000_8000);
        rd(ADDR_SCR, 32'h0000_0000);
        chk(32'(n_pulse), 32'h0000_0001);
        finish_test();
    end
    initial begin
        #2_000_000;
        n_fail++;
        finish_test();
    end
endmodule
